// ===== rtl/odcu_consts.svh
// constants of the on-chip debug command unit
`ifndef ODCU_CONSTS_SVH
`define ODCU_CONSTS_SVH

// =====================================================
// command codes
`define ODCU_CMD_CRC 8'h0e
`define ODCU_CMD_STEP 8'h10
`define ODCU_CMD_STUFF 8'h11
`define ODCU_CMD_EXEC 8'h12

// =====================================================
// debug control register fields
`define ODCU_CTL_DBG_BIT 7
`define ODCU_CTL_BRK_BIT 6
`define ODCU_CTL_RST_BIT 0
`define ODCU_CTL_RESET_STOP 8'h81
`define ODCU_CTL_RESET_GO 8'h41
`define ODCU_CTL_RUN 8'h40
`define ODCU_CTL_RESET_VAL 8'h00

// =====================================================
// crc and instruction sizes
`define ODCU_CRC_INIT 16'hffff
`define ODCU_CRC_POLY 16'h1021
`define ODCU_STUFF_LEN 3'h1
`define ODCU_IDX_ZERO 3'h0
`define ODCU_IDX_ONE 3'h1

`endif

// ===== rtl/odcu_pkg.sv
// types of the on-chip debug command unit
package odcu_pkg;

	// gray coded along idle -> args -> exec and idle -> crc -> hi -> lo
	typedef enum logic [2:0] {
		ODCU_IDLE = 3'h0,
		ODCU_ARGS = 3'h1,
		ODCU_EXEC = 3'h3,
		ODCU_CRC = 3'h2,
		ODCU_SEND_HI = 3'h6,
		ODCU_SEND_LO = 3'h7,
		ODCU_DISC = 3'h5
	} odcu_state_t;

	typedef enum logic [1:0] {
		ODCU_MODE_STEP = 2'h0,
		ODCU_MODE_STUFF = 2'h1,
		ODCU_MODE_FULL = 2'h2
	} odcu_mode_t;

endpackage

// ===== rtl/odcu_crc16.sv
// byte-wide crc16 accumulator, msb first
`include "odcu_consts.svh"
module odcu_crc16 #(
	parameter logic [15:0] POLY = `ODCU_CRC_POLY
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic en,
	input wire logic [7:0] din,
	output logic [15:0] crc
);
	logic [15:0] crc_q;
	logic [15:0] stage [0:8];

	// =====================================================
	// one shift stage per data bit
	assign stage[0] = crc_q;
	generate
		for (genvar i = 0; i < 8; i++) begin : g_bit
			assign stage[i + 1] = {stage[i][14:0], 1'b0} ^
				((stage[i][15] ^ din[7 - i]) ? POLY : 16'h0000);
		end
	endgenerate

	// =====================================================
	// clear wins so a new run never mixes with the old sum
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			crc_q <= `ODCU_CRC_INIT;
		end else if (clear) begin
			crc_q <= `ODCU_CRC_INIT;
		end else if (en) begin
			crc_q <= stage[8];
		end
	end

	assign crc = crc_q;
endmodule

// ===== rtl/odcu_cmd.sv
// debug command unit: crc readback, step, stuff, execute, control writes
//
// Behaviour
// - crc command 0eh sums all program memory, one byte a cycle, sends high then low
// - command 10h steps one instruction from the program counter
// - step and stuff do nothing unless halted and read protect is off
// - command 11h takes one opcode byte; core fetches remaining bytes itself
// - command 12h takes a whole instruction, length from its opcode, to the core
// - refused execute command swallows exactly one byte and runs nothing
// - supplied instructions may run over a breakpoint location
// - control write enters or leaves debug, enables break, resets device
// - control value 81h resets device and keeps it halted
// - control value 41h resets device and lets it run
// - control value 40h while halted releases the core without reset
`include "odcu_consts.svh"
module odcu_cmd #(
	parameter int ADDR_W = 16,
	parameter int PM_BYTES = 12288
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic read_protect,
	input wire logic ctl_wr,
	input wire logic [7:0] ctl_wdata,
	input wire logic break_hit,
	output logic debug_mode,
	output logic brk_enable,
	output logic device_reset,
	output logic [ADDR_W-1:0] pm_addr,
	output logic pm_rd,
	input wire logic [7:0] pm_rdata,
	input wire logic [2:0] op_len,
	output logic cpu_exec_req,
	output logic [1:0] cpu_exec_mode,
	output logic [2:0] cpu_exec_len,
	output logic [39:0] cpu_exec_bytes,
	output logic cpu_skip_bp,
	input wire logic cpu_exec_done
);
	localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(PM_BYTES - 1);

	odcu_pkg::odcu_state_t state_q;
	logic dbg_q;
	logic brk_q;
	logic rst_q;
	logic allowed;
	logic cmd_take;
	logic [7:0] cmd_q;
	logic [2:0] idx_q;
	logic [2:0] need_q;
	logic [39:0] bytes_q;
	logic [1:0] mode_q;
	logic [2:0] len_q;
	logic req_q;
	logic [ADDR_W-1:0] addr_q;
	logic issue_q;
	logic pend_q;
	logic crc_clear;
	logic [15:0] crc_val;
	logic [7:0] tx_data_q;
	logic tx_valid_q;

	assign allowed = dbg_q && !read_protect;
	assign cmd_take = (state_q == odcu_pkg::ODCU_IDLE) && rx_valid;

	// =====================================================
	// debug control register
	// control register fields
	// reset bit and debug bit act together
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dbg_q <= 1'(`ODCU_CTL_RESET_VAL >> `ODCU_CTL_DBG_BIT);
			brk_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rst_q <= ctl_wr && ctl_wdata[`ODCU_CTL_RST_BIT];
			if (ctl_wr) begin
				brk_q <= ctl_wdata[`ODCU_CTL_BRK_BIT];
			end
			// a break in the same cycle as a run write still halts
			if (break_hit && brk_q) begin
				dbg_q <= 1'b1;
			end else if (ctl_wr) begin
				dbg_q <= ctl_wdata[`ODCU_CTL_DBG_BIT];
			end
		end
	end

	assign debug_mode = dbg_q;
	assign brk_enable = brk_q;
	assign device_reset = rst_q;

	// =====================================================
	// command sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= odcu_pkg::ODCU_IDLE;
			cmd_q <= 8'h00;
		end else begin
			unique case (state_q)
				odcu_pkg::ODCU_IDLE: begin
					if (rx_valid) begin
						cmd_q <= rx_data;
						unique case (rx_data)
							`ODCU_CMD_CRC: state_q <= odcu_pkg::ODCU_CRC;
							// step only when halted and unprotected
							`ODCU_CMD_STEP: state_q <= allowed ? odcu_pkg::ODCU_EXEC :
								odcu_pkg::ODCU_IDLE;
							`ODCU_CMD_STUFF: state_q <= allowed ? odcu_pkg::ODCU_ARGS :
								odcu_pkg::ODCU_IDLE;
							`ODCU_CMD_EXEC: state_q <= allowed ? odcu_pkg::ODCU_ARGS :
								odcu_pkg::ODCU_DISC;
							default: state_q <= odcu_pkg::ODCU_IDLE;
						endcase
					end
				end
				odcu_pkg::ODCU_ARGS: begin
					if (rx_valid && ((idx_q == `ODCU_IDX_ZERO) ?
						(cmd_q == `ODCU_CMD_STUFF || op_len <= `ODCU_IDX_ONE) :
						(idx_q + `ODCU_IDX_ONE == need_q))) begin
						state_q <= odcu_pkg::ODCU_EXEC;
					end
				end
				odcu_pkg::ODCU_EXEC: if (cpu_exec_done) state_q <= odcu_pkg::ODCU_IDLE;
				// whatever the next byte holds, it is dropped
				odcu_pkg::ODCU_DISC: if (rx_valid) state_q <= odcu_pkg::ODCU_IDLE;
				odcu_pkg::ODCU_CRC: begin
					if (!issue_q && !pend_q) begin
						state_q <= odcu_pkg::ODCU_SEND_HI;
					end
				end
				odcu_pkg::ODCU_SEND_HI: if (tx_ready) state_q <= odcu_pkg::ODCU_SEND_LO;
				odcu_pkg::ODCU_SEND_LO: if (tx_ready) state_q <= odcu_pkg::ODCU_IDLE;
				// code 3'h4 is unused; an upset lands back in idle
				default: state_q <= odcu_pkg::ODCU_IDLE;
			endcase
		end
	end

	// =====================================================
	// instruction byte gathering
	// stuff takes one byte, core reads the rest from memory
	// execute takes as many bytes as the opcode asks
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_q <= `ODCU_IDX_ZERO;
			need_q <= `ODCU_IDX_ONE;
			bytes_q <= 40'h00_0000_0000;
		end else if (cmd_take) begin
			idx_q <= `ODCU_IDX_ZERO;
			bytes_q <= 40'h00_0000_0000;
		end else if (state_q == odcu_pkg::ODCU_ARGS && rx_valid) begin
			if (idx_q == `ODCU_IDX_ZERO) begin
				need_q <= (cmd_q == `ODCU_CMD_STUFF) ? `ODCU_STUFF_LEN : op_len;
			end
			bytes_q[idx_q * 8 +: 8] <= rx_data;
			idx_q <= idx_q + `ODCU_IDX_ONE;
		end
	end

	// =====================================================
	// core execute request, one pulse per accepted step, stuff or execute command
	// supplied instructions run over breakpoints
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			req_q <= 1'b0;
			mode_q <= odcu_pkg::ODCU_MODE_STEP;
			len_q <= `ODCU_IDX_ZERO;
		end else begin
			req_q <= 1'b0;
			if (cmd_take && rx_data == `ODCU_CMD_STEP && allowed) begin
				req_q <= 1'b1;
				mode_q <= odcu_pkg::ODCU_MODE_STEP;
				len_q <= `ODCU_IDX_ZERO;
			end else if (state_q == odcu_pkg::ODCU_ARGS && rx_valid &&
				((idx_q == `ODCU_IDX_ZERO) ? (cmd_q == `ODCU_CMD_STUFF ||
				op_len <= `ODCU_IDX_ONE) : (idx_q + `ODCU_IDX_ONE == need_q))) begin
				req_q <= 1'b1;
				mode_q <= (cmd_q == `ODCU_CMD_STUFF) ? odcu_pkg::ODCU_MODE_STUFF :
					odcu_pkg::ODCU_MODE_FULL;
				len_q <= idx_q + `ODCU_IDX_ONE;
			end
		end
	end

	assign cpu_exec_req = req_q;
	assign cpu_exec_mode = mode_q;
	assign cpu_exec_len = len_q;
	assign cpu_exec_bytes = bytes_q;
	assign cpu_skip_bp = (mode_q != odcu_pkg::ODCU_MODE_STEP);

	// =====================================================
	// crc memory sweep, one read a cycle
	// whole program memory, address 0 upward
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_q <= '0;
			issue_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			pend_q <= pm_rd;
			if (cmd_take && rx_data == `ODCU_CMD_CRC) begin
				addr_q <= '0;
				issue_q <= 1'b1;
			end else if (pm_rd) begin
				addr_q <= addr_q + ADDR_W'(1);
				issue_q <= (addr_q != LAST_ADDR);
			end
		end
	end

	assign pm_rd = (state_q == odcu_pkg::ODCU_CRC) && issue_q;
	assign pm_addr = addr_q;
	assign crc_clear = cmd_take && rx_data == `ODCU_CMD_CRC;

	odcu_crc16 #(
		.POLY(`ODCU_CRC_POLY)
	) u_crc (
		.clk(clk),
		.reset_n(reset_n),
		.clear(crc_clear),
		.en(pend_q),
		.din(pm_rdata),
		.crc(crc_val)
	);

	// =====================================================
	// result bytes to the transmitter
	// high byte first, then low byte
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_data_q <= 8'h00;
			tx_valid_q <= 1'b0;
		end else if (state_q == odcu_pkg::ODCU_CRC && !issue_q && !pend_q) begin
			tx_data_q <= crc_val[15:8];
			tx_valid_q <= 1'b1;
		end else if (state_q == odcu_pkg::ODCU_SEND_HI && tx_ready) begin
			tx_data_q <= crc_val[7:0];
		end else if (state_q == odcu_pkg::ODCU_SEND_LO && tx_ready) begin
			tx_valid_q <= 1'b0;
		end
	end

	assign tx_data = tx_data_q;
	assign tx_valid = tx_valid_q;
	// =====================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	step_request_a: assert property (cmd_take && rx_data == `ODCU_CMD_STEP && allowed
		|=> cpu_exec_req && cpu_exec_mode == odcu_pkg::ODCU_MODE_STEP)
		else $error("step command gave no step request");
	refuse_quiet_a: assert property (cmd_take && !allowed &&
		(rx_data == `ODCU_CMD_STEP || rx_data == `ODCU_CMD_STUFF)
		|=> !cpu_exec_req [*2] ##0 state_q == odcu_pkg::ODCU_IDLE)
		else $error("refused command still acted");
	discard_enter_a: assert property (cmd_take && !allowed && rx_data == `ODCU_CMD_EXEC
		|=> state_q == odcu_pkg::ODCU_DISC && !cpu_exec_req)
		else $error("refused execute did not wait for its byte");
	discard_one_a: assert property (state_q == odcu_pkg::ODCU_DISC && rx_valid
		|=> state_q == odcu_pkg::ODCU_IDLE && !cpu_exec_req && !pm_rd)
		else $error("refused execute did not discard one byte");
	stuff_length_a: assert property (cpu_exec_req &&
		cpu_exec_mode == odcu_pkg::ODCU_MODE_STUFF |-> cpu_exec_len == `ODCU_STUFF_LEN)
		else $error("stuff request carries wrong length");
	skip_break_a: assert property (cpu_exec_req
		|-> cpu_skip_bp == (cmd_q != `ODCU_CMD_STEP))
		else $error("supplied instruction does not pass breakpoint");
	crc_order_a: assert property (state_q == odcu_pkg::ODCU_SEND_HI && tx_ready
		|-> tx_data == crc_val[15:8] ##1 tx_valid && tx_data == $past(crc_val[7:0]))
		else $error("crc bytes out of order");
	reset_stop_a: assert property (ctl_wr && ctl_wdata == `ODCU_CTL_RESET_STOP
		|=> device_reset && debug_mode)
		else $error("reset and stop failed");
	reset_go_a: assert property (ctl_wr && ctl_wdata == `ODCU_CTL_RESET_GO &&
		!break_hit |=> device_reset && !debug_mode)
		else $error("reset and go failed");
	run_release_a: assert property (debug_mode && ctl_wr &&
		ctl_wdata == `ODCU_CTL_RUN && !break_hit |=> !debug_mode && !device_reset)
		else $error("run write did not release core");
	no_mem_a: assert property (cmd_take && !allowed && rx_data != `ODCU_CMD_CRC
		|=> !pm_rd && !cpu_exec_req && !tx_valid)
		else $error("ignored command touched core or memory");
endmodule

// ===== sim/odcu_host_model.sv
// debug host model: sends command bytes, takes result bytes slowly
module odcu_host_model (
	input wire logic clk,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] stall_q = 2'h0;
	logic [7:0] got[$];
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
	end
	// =====================================================
	// byte sender
	// command byte first
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		rx_data <= b;
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b; // stale byte never looks valid
	endtask
	// =====================================================
	// slow taker, ready one cycle in three, to stress the holding of tx
	assign tx_ready = (stall_q == 2'h2);
	always @(posedge clk) begin
		stall_q <= (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
		if (tx_valid && tx_ready) got.push_back(tx_data);
	end
endmodule

// ===== sim/onchip_debug_command_unit_tb.sv
// testbench of the debug command unit
module onchip_debug_command_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PMB = 16;
	logic clk, reset_n, read_protect, ctl_wr, cpu_exec_done, d1_q, seen;
	logic [7:0] ctl_wdata, pm_rdata, rx_data, tx_data;
	logic rx_valid, tx_valid, tx_ready, debug_mode, brk_enable, device_reset;
	logic pm_rd, cpu_exec_req, cpu_skip_bp, break_hit;
	logic rd_seen = 1'b0;
	logic [15:0] pm_addr, crc;
	logic [2:0] op_len, cpu_exec_len;
	logic [1:0] cpu_exec_mode;
	logic [39:0] cpu_exec_bytes;
	int n_fail = 0;
	int total_checks = 0;
	odcu_cmd #(.ADDR_W(16), .PM_BYTES(PMB)) u_dut (.clk(clk), .reset_n(reset_n),
		.rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .read_protect(read_protect), .ctl_wr(ctl_wr),
		.ctl_wdata(ctl_wdata), .break_hit(break_hit), .debug_mode(debug_mode),
		.brk_enable(brk_enable), .device_reset(device_reset), .pm_addr(pm_addr),
		.pm_rd(pm_rd), .pm_rdata(pm_rdata), .op_len(op_len), .cpu_exec_req(cpu_exec_req),
		.cpu_exec_mode(cpu_exec_mode), .cpu_exec_len(cpu_exec_len),
		.cpu_exec_bytes(cpu_exec_bytes), .cpu_skip_bp(cpu_skip_bp),
		.cpu_exec_done(cpu_exec_done));
	odcu_host_model host (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
	// =====================================================
	// clock, memory and core stand-ins
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [7:0] mem_at(input logic [15:0] a);
		return a[7:0] * 8'h03 + 8'h01;
	endfunction
	assign op_len = {1'b0, rx_data[1:0]} + 3'h1; // length from the two low opcode bits
	// memory answers a cycle late, core finishes two cycles after a request
	always @(posedge clk) begin
		pm_rdata <= mem_at(pm_addr);
		d1_q <= cpu_exec_req;
		cpu_exec_done <= d1_q;
		if (pm_rd === 1'b1) rd_seen <= 1'b1; // any memory read so far
	end
	// =====================================================
	// shared tasks
	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wait_req();
		seen = 1'b0;
		repeat (6) begin
			@(negedge clk);
			if (cpu_exec_req === 1'b1) begin
				seen = 1'b1;
				break;
			end
		end
	endtask
	task automatic ctl(input logic [7:0] v);
		@(posedge clk);
		ctl_wr <= 1'b1;
		ctl_wdata <= v;
		@(posedge clk);
		ctl_wr <= 1'b0;
		@(negedge clk);
	endtask
	// =====================================================
	// scenarios
	task automatic t_refused();
		host.send(8'h10);
		wait_req();
		chk("step while running", 0, seen);
		// a crc code as the swallowed byte would start a memory sweep if parsed
		host.send(8'h12);
		host.send(8'h0e);
		repeat (4) @(posedge clk);
		chk("swallowed byte", 0, rd_seen);
		ctl(8'h81);
		@(posedge clk);
		read_protect <= 1'b1;
		host.send(8'h11);
		wait_req();
		chk("stuff protected", 0, seen);
		// protection drops before the next byte: only the discard stops a step
		host.send(8'h12);
		read_protect <= 1'b0;
		host.send(8'h10);
		wait_req();
		chk("exec protected", 0, seen);
		chk("memory untouched", 0, rd_seen);
		$display("test refused done");
	endtask
	task automatic t_control();
		ctl(8'h81);
		chk("reset pulse", 1, device_reset);
		chk("halted", 1, debug_mode);
		@(negedge clk);
		chk("reset ends", 0, device_reset);
		ctl(8'h41);
		chk("reset go", 1, device_reset);
		chk("running", 0, debug_mode);
		ctl(8'h81);
		ctl(8'h40);
		chk("run no reset", 0, device_reset);
		chk("released", 0, debug_mode);
		chk("break enabled", 1, brk_enable);
		ctl(8'h81);
		$display("test control done");
	endtask
	task automatic t_break();
		ctl(8'h40);
		@(posedge clk);
		break_hit <= 1'b1;
		@(posedge clk);
		break_hit <= 1'b0;
		@(negedge clk);
		chk("break halts", 1, debug_mode);
		ctl(8'h00);
		chk("break disabled", 0, brk_enable);
		@(posedge clk);
		break_hit <= 1'b1;
		@(posedge clk);
		break_hit <= 1'b0;
		@(negedge clk);
		chk("break ignored", 0, debug_mode);
		ctl(8'h81);
		$display("test break done");
	endtask
	task automatic t_exec();
		host.send(8'h10);
		wait_req();
		chk("step req", 1, seen);
		chk("step mode", 40'(0), {cpu_skip_bp, cpu_exec_len, cpu_exec_mode});
		repeat (4) @(posedge clk);
		host.send(8'h11);
		host.send(8'ha5);
		wait_req();
		chk("stuff", {1'b1, 3'h1, 2'h1, 8'ha5},
			{cpu_skip_bp, cpu_exec_len, cpu_exec_mode, cpu_exec_bytes[7:0]});
		repeat (4) @(posedge clk);
		// low opcode bits 00 make a one-byte instruction
		host.send(8'h12);
		host.send(8'h40);
		wait_req();
		chk("exec one byte", {1'b1, 3'h1, 2'h2, 8'h40},
			{cpu_skip_bp, cpu_exec_len, cpu_exec_mode, cpu_exec_bytes[7:0]});
		repeat (4) @(posedge clk);
		host.send(8'h12);
		host.send(8'h32);
		host.send(8'h5a);
		host.send(8'hc3);
		wait_req();
		chk("exec", {1'b1, 3'h3, 2'h2, 24'hc35a32},
			{cpu_skip_bp, cpu_exec_len, cpu_exec_mode, cpu_exec_bytes[23:0]});
		repeat (4) @(posedge clk);
		$display("test execute done");
	endtask
	task automatic t_crc();
		crc = 16'hffff;
		for (int a = 0; a < PMB; a++) begin
			crc ^= {mem_at(16'(a)), 8'h00};
			for (int k = 0; k < 8; k++) crc = crc[15] ? (crc << 1) ^ 16'h1021 : crc << 1;
		end
		host.got.delete();
		host.send(8'h0e);
		for (int i = 0; i < 200 && host.got.size() < 2; i++) @(posedge clk);
		chk("crc bytes", 2, host.got.size());
		if (host.got.size() == 2) chk("crc", crc, {host.got[0], host.got[1]});
		$display("test crc done");
	endtask
	// =====================================================
	// verdict and main sequence
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#20000;
		n_fail++;
		$display("unexpected timeout: expected end, seen hang");
		tally_and_finish();
	end
	initial begin
		reset_n = 1'b0;
		read_protect = 1'b0;
		ctl_wr = 1'b0;
		ctl_wdata = 8'h00;
		break_hit = 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		t_refused();
		t_control();
		t_break();
		t_exec();
		t_crc();
		tally_and_finish();
	end
endmodule
